// *** ccd_pkg.sv ***
package ccd_pkg;
  // Register offsets (byte addresses on the plain register port)
  localparam logic [9:0] ONE_CYCLES_OFS = 10'h193;
  localparam logic [9:0] ONE_CONTROL_OFS = 10'h194;
  localparam logic [9:0] ONE_ROUTING_OFS = 10'h195;
  localparam logic [9:0] TWO_CYCLES_OFS = 10'h196;
  localparam logic [9:0] TWO_CONTROL_OFS = 10'h197;
  localparam logic [9:0] TWO_ROUTING_OFS = 10'h198;
  localparam logic [9:0] SOURCE_SEL_OFS = 10'h1e1;
  // Field positions
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int HIGH_LSB = 0;
  localparam int BYPASS_BIT = 7;
  localparam int NOSYNC_BIT = 6;
  localparam int FORCE_BIT = 5;
  localparam int START_BIT = 4;
  localparam int PHASE_MSB = 3;
  localparam int PHASE_LSB = 0;
  localparam int DIRECT_BIT = 1;
  localparam int DUTY_BIT = 0;
  // Reset values
  localparam logic [7:0] CYCLES_RST = 8'h00;
  localparam logic [7:0] ONE_CONTROL_RST = 8'h00;
  localparam logic [7:0] TWO_CONTROL_RST = 8'h80;
  localparam logic [7:0] ROUTING_RST = 8'h00;
  localparam logic [7:0] SOURCE_SEL_RST = 8'h00;
  // Distribution source select codes
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_DIV = 2'h1;
  localparam logic [1:0] SRC_OSC = 2'h2;
endpackage : ccd_pkg

// *** ccd_divider.sv ***
module ccd_divider (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Distribution clock enable, one pulse per input clock cycle
  input wire logic tick,
  // Settings
  input wire logic [3:0] low_cycles,
  input wire logic [3:0] high_cycles,
  input wire logic bypass,
  input wire logic nosync,
  input wire logic force_high,
  input wire logic start_high,
  input wire logic [3:0] phase,
  input wire logic sync,
  // Divided output
  output logic div_out
);
  typedef enum logic [1:0] {CCD_IDLE, CCD_DELAY, CCD_RUN} ccd_state_e;
  ccd_state_e st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic lvl_q, lvl_d;
  logic [3:0] len;

  // Length of the current half period
  assign len = lvl_q ? high_cycles : low_cycles;

  // Next state of the counter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (bypass) begin
      st_d = CCD_IDLE;
      cnt_d = 4'h0;
    end else if (nosync) begin
      st_d = CCD_IDLE;
      lvl_d = force_high;
      cnt_d = 4'h0;
    end else if (sync || st_q == CCD_IDLE) begin
      st_d = CCD_DELAY;
      lvl_d = start_high;
      cnt_d = phase;
    end else if (tick) begin
      case (st_q)
        CCD_DELAY: begin
          if (cnt_q == 4'h0) begin
            st_d = CCD_RUN;
            cnt_d = len;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        CCD_RUN: begin
          if (cnt_q == 4'h0) begin
            lvl_d = ~lvl_q;
            cnt_d = lvl_q ? low_cycles : high_cycles;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        default: st_d = CCD_IDLE;
      endcase
    end
  end

  // Counter registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= CCD_IDLE;
      cnt_q <= 4'h0;
      lvl_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  // Bypass passes the input clock through
  assign div_out = bypass ? tick : lvl_q;

  a_force_level: assert property (@(posedge clock) disable iff (!reset_n)
    (!bypass && nosync) |=> (bypass || div_out == $past(force_high))) else $error("forced level wrong");
  a_sync_start: assert property (@(posedge clock) disable iff (!reset_n)
    (!bypass && !nosync && sync) |=> (bypass || div_out == $past(start_high))) else $error("start level wrong");
endmodule : ccd_divider

// *** ccd_router.sv ***
module ccd_router (
  // Sources
  input wire logic div_out,
  input wire logic osc_clk,
  input wire logic ext_clk,
  // Routing controls
  input wire logic direct,
  input wire logic [1:0] source_sel,
  // Selected pair clock
  output logic pair_clk
);
  // Direct routing picks oscillator or external clock; code 01b leaves the divider
  always_comb begin
    pair_clk = div_out;
    if (direct) begin
      case (source_sel)
        ccd_pkg::SRC_OSC: pair_clk = osc_clk;
        ccd_pkg::SRC_EXT: pair_clk = ext_clk;
        ccd_pkg::SRC_DIV: pair_clk = div_out;
        default: pair_clk = div_out;
      endcase
    end
  end
endmodule : ccd_router

// *** ccd_top.sv ***
// What this block does
// - Output stays low for low-cycle field plus one input cycles.
// - Output stays high for high-cycle field plus one input cycles.
// - Control bit 7 bypasses the counter and passes input clock through.
// - Divider one resets used; divider two resets bypassed.
// - Control bit 6 set makes the divider ignore chip synchronisation.
// - Bit 5 forces static level, only with bit 6 also set.
// - Start-level bit picks whether divided clock starts low or high.
// - Four-bit phase offset delays starting phase in input cycles.
// - Direct bit routes oscillator (10b) or external clock (00b) to outputs.
// - Source select 01b makes the direct bit ineffective.
// - Routing bit 0 clear applies duty correction; set disables it.
// - Divider two is identical, cycles at divider_two_cycles, control at divider_two_control.
module ccd_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [9:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // Distribution sources, sampled as enables
  input wire logic osc_clk,
  input wire logic ext_clk,
  input wire logic chip_sync,
  // Channel one pair
  output logic pair_output_a,
  output logic pair_output_b,
  // Channel two pair
  output logic pair2_output_a,
  output logic pair2_output_b,
  // Duty correction enables
  output logic duty_fix_en_one,
  output logic duty_fix_en_two
);
  logic [7:0] cyc_q [2];
  logic [7:0] cyc_d [2];
  logic [7:0] ctl_q [2];
  logic [7:0] ctl_d [2];
  logic [7:0] rte_q [2];
  logic [7:0] rte_d [2];
  logic [7:0] src_q, src_d;
  logic [7:0] rd_q, rd_d;
  logic tick;
  logic [1:0] pair_clk;
  logic [1:0] pair_a_q, pair_b_q;

  // Distribution clock: oscillator or external per source select
  assign tick = (src_q[1:0] == ccd_pkg::SRC_OSC) ? osc_clk : ext_clk;

  // Register writes and read data
  always_comb begin
    cyc_d = cyc_q;
    ctl_d = ctl_q;
    rte_d = rte_q;
    src_d = src_q;
    rd_d = 8'h00;
    if (reg_write) begin
      case (reg_addr)
        ccd_pkg::ONE_CYCLES_OFS: cyc_d[0] = reg_wdata;
        ccd_pkg::ONE_CONTROL_OFS: ctl_d[0] = reg_wdata;
        ccd_pkg::ONE_ROUTING_OFS: rte_d[0] = reg_wdata & 8'h03;
        ccd_pkg::TWO_CYCLES_OFS: cyc_d[1] = reg_wdata;
        ccd_pkg::TWO_CONTROL_OFS: ctl_d[1] = reg_wdata;
        ccd_pkg::TWO_ROUTING_OFS: rte_d[1] = reg_wdata & 8'h03;
        ccd_pkg::SOURCE_SEL_OFS: src_d = reg_wdata & 8'h03;
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        ccd_pkg::ONE_CYCLES_OFS: rd_d = cyc_q[0];
        ccd_pkg::ONE_CONTROL_OFS: rd_d = ctl_q[0];
        ccd_pkg::ONE_ROUTING_OFS: rd_d = rte_q[0];
        ccd_pkg::TWO_CYCLES_OFS: rd_d = cyc_q[1];
        ccd_pkg::TWO_CONTROL_OFS: rd_d = ctl_q[1];
        ccd_pkg::TWO_ROUTING_OFS: rd_d = rte_q[1];
        ccd_pkg::SOURCE_SEL_OFS: rd_d = src_q;
        default: rd_d = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cyc_q[0] <= ccd_pkg::CYCLES_RST;
      cyc_q[1] <= ccd_pkg::CYCLES_RST;
      ctl_q[0] <= ccd_pkg::ONE_CONTROL_RST;
      ctl_q[1] <= ccd_pkg::TWO_CONTROL_RST;
      rte_q[0] <= ccd_pkg::ROUTING_RST;
      rte_q[1] <= ccd_pkg::ROUTING_RST;
      src_q <= ccd_pkg::SOURCE_SEL_RST;
      rd_q <= 8'h00;
    end else begin
      cyc_q <= cyc_d;
      ctl_q <= ctl_d;
      rte_q <= rte_d;
      src_q <= src_d;
      rd_q <= rd_d;
    end
  end

  assign reg_rdata = rd_q;

  // One divider and router per channel
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic div_out;
    ccd_divider u_div (
      .clock(clock),
      .reset_n(reset_n),
      .tick(tick),
      .low_cycles(cyc_q[i][ccd_pkg::LOW_MSB:ccd_pkg::LOW_LSB]),
      .high_cycles(cyc_q[i][ccd_pkg::HIGH_MSB:ccd_pkg::HIGH_LSB]),
      .bypass(ctl_q[i][ccd_pkg::BYPASS_BIT]),
      .nosync(ctl_q[i][ccd_pkg::NOSYNC_BIT]),
      .force_high(ctl_q[i][ccd_pkg::FORCE_BIT]),
      .start_high(ctl_q[i][ccd_pkg::START_BIT]),
      .phase(ctl_q[i][ccd_pkg::PHASE_MSB:ccd_pkg::PHASE_LSB]),
      .sync(chip_sync),
      .div_out(div_out)
    );
    ccd_router u_rte (
      .div_out(div_out),
      .osc_clk(osc_clk),
      .ext_clk(ext_clk),
      .direct(rte_q[i][ccd_pkg::DIRECT_BIT]),
      .source_sel(src_q[1:0]),
      .pair_clk(pair_clk[i])
    );
  end

  // Output pairs registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pair_a_q <= 2'h0;
      pair_b_q <= 2'h0;
    end else begin
      pair_a_q <= pair_clk;
      pair_b_q <= pair_clk;
    end
  end

  assign pair_output_a = pair_a_q[0];
  assign pair_output_b = pair_b_q[0];
  assign pair2_output_a = pair_a_q[1];
  assign pair2_output_b = pair_b_q[1];
  assign duty_fix_en_one = ~rte_q[0][ccd_pkg::DUTY_BIT];
  assign duty_fix_en_two = ~rte_q[1][ccd_pkg::DUTY_BIT];

  a_read_data: assert property (@(posedge clock) disable iff (!reset_n)
    (reg_read && reg_addr == ccd_pkg::TWO_CONTROL_OFS && !reg_write) |=> (reg_rdata == ctl_q[1])) else $error("read data wrong");
  a_duty_ctl: assert property (@(posedge clock) disable iff (!reset_n)
    (reg_write && reg_addr == ccd_pkg::ONE_ROUTING_OFS) |=> (duty_fix_en_one == !$past(reg_wdata[0]))) else $error("duty bad");
  a_route_div: assert property (@(posedge clock) disable iff (!reset_n)
    (src_q[1:0] == ccd_pkg::SRC_DIV) |=> (pair_output_a == $past(g_ch[0].div_out))) else $error("route bad");
  a_route_osc: assert property (@(posedge clock) disable iff (!reset_n)
    (rte_q[0][1] && src_q[1:0] == ccd_pkg::SRC_OSC) |=> (pair_output_b == $past(osc_clk))) else $error("osc bad");
  a_reset_bypass: assert property (@(posedge clock) disable iff (!reset_n)
    $rose(reset_n) |-> (ctl_q[1][7] && !ctl_q[0][7])) else $error("bypass reset");
  a_bypass_pass: assert property (@(posedge clock) disable iff (!reset_n)
    (ctl_q[1][7] && !rte_q[1][1]) |=> (pair2_output_a == $past(tick))) else $error("bypass");
endmodule : ccd_top

// *** ccd_sink.sv ***
module ccd_sink (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Received clock level
  input wire logic level,
  // Last finished high and low run lengths, in system cycles
  output logic [7:0] hi_len,
  output logic [7:0] lo_len
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_q;
  logic [7:0] run_q;
  // Measure each run of constant level as a receiver would
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
      run_q <= 8'h00;
      hi_len <= 8'h00;
      lo_len <= 8'h00;
    end else if (level !== prev_q) begin
      if (prev_q) hi_len <= run_q;
      else lo_len <= run_q;
      prev_q <= level;
      run_q <= 8'h01;
    end else if (run_q != 8'hff) begin
      run_q <= run_q + 8'h01;
    end
  end
endmodule : ccd_sink

// *** tb_clock_channel_divider.sv ***
module tb_clock_channel_divider;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset_n, reg_write, reg_read, osc_clk, ext_clk, chip_sync;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got, hi1, lo1, hi2, lo2;
  logic pa, pb, p2a, p2b, dfe1, dfe2;
  int error_cnt, tests_run, cyc;
  logic [9:0] ra [8] = '{10'h193, 10'h194, 10'h195, 10'h196, 10'h197, 10'h198, 10'h1e1, 10'h000};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00};
  ccd_top dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .osc_clk(osc_clk),
    .ext_clk(ext_clk), .chip_sync(chip_sync), .pair_output_a(pa), .pair_output_b(pb),
    .pair2_output_a(p2a), .pair2_output_b(p2b), .duty_fix_en_one(dfe1), .duty_fix_en_two(dfe2));
  ccd_sink sink_one (.clock(clock), .reset_n(reset_n), .level(pa), .hi_len(hi1), .lo_len(lo1));
  ccd_sink sink_two (.clock(clock), .reset_n(reset_n), .level(p2a), .hi_len(hi2), .lo_len(lo2));
  // Clock at 40 MHz
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // Hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // One register write cycle
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  // One register read cycle, data taken in the following cycle
  task automatic rd(input logic [9:0] a);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    got = reg_rdata;
  endtask : rd
  // Let outputs settle for n cycles
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask : wt
  // Compare one value
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    {reset_n, reg_write, reg_read, osc_clk, chip_sync, cyc, error_cnt, tests_run} = '0;
    {reg_addr, reg_wdata} = '0;
    ext_clk = 1'b1;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      chk("reset reg", rv[i], got);
    end
    chk("pair2 bypass", 8'h03, {6'h0, p2a, p2b});
    chk("duty one", 8'h01, {7'h0, dfe1});
    $display("reset test done");
    wr(ccd_pkg::ONE_CYCLES_OFS, 8'h21);
    rd(ccd_pkg::ONE_CYCLES_OFS);
    chk("cycles rb", 8'h21, got);
    wr(ccd_pkg::TWO_CYCLES_OFS, 8'h30);
    wr(ccd_pkg::TWO_CONTROL_OFS, 8'h00);
    wt(40);
    chk("one high", 8'h02, hi1);
    chk("one low", 8'h03, lo1);
    chk("two high", 8'h01, hi2);
    chk("two low", 8'h04, lo2);
    $display("divide test done");
    wr(ccd_pkg::ONE_CONTROL_OFS, 8'h80);
    wt(3);
    chk("bypass hi", 8'h01, {7'h0, pa});
    @(posedge clock);
    ext_clk <= 1'b0;
    wt(3);
    chk("bypass lo", 8'h00, {7'h0, pa});
    @(posedge clock);
    ext_clk <= 1'b1;
    chip_sync <= 1'b1;
    wr(ccd_pkg::ONE_CONTROL_OFS, 8'h60);
    wt(3);
    chk("force hi", 8'h03, {6'h0, pa, pb});
    wr(ccd_pkg::ONE_CONTROL_OFS, 8'h40);
    wt(3);
    chk("force lo", 8'h00, {6'h0, pa, pb});
    $display("bypass force test done");
    for (int s = 0; s < 2; s++) begin
      wr(ccd_pkg::ONE_CONTROL_OFS, s ? 8'h12 : 8'h02);
      wt(4);
      chk("sync start", 8'(s), {7'h0, pa});
      @(posedge clock);
      chip_sync <= 1'b0;
      wt(2);
      chk("phase hold", 8'(s), {7'h0, pa});
      wt(40);
      chk("sync high", 8'h02, hi1);
      @(posedge clock);
      if (s == 0) chip_sync <= 1'b1;
    end
    $display("sync test done");
    wr(ccd_pkg::ONE_ROUTING_OFS, 8'h02);
    for (int i = 0; i < 6; i++) begin
      wt(1);
      chk("direct ext", 8'h01, {7'h0, pa});
    end
    wr(ccd_pkg::SOURCE_SEL_OFS, 8'h02);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      osc_clk <= i[0];
      wt(3);
      chk("direct osc", 8'(i[0]), {7'h0, pa});
    end
    @(posedge clock);
    osc_clk <= 1'b0;
    wr(ccd_pkg::SOURCE_SEL_OFS, 8'h01);
    wt(40);
    chk("no direct hi", 8'h02, hi1);
    chk("no direct lo", 8'h03, lo1);
    $display("routing test done");
    wr(ccd_pkg::ONE_ROUTING_OFS, 8'h01);
    wt(1);
    chk("duty off one", 8'h01, {6'h0, dfe1, dfe2});
    wr(ccd_pkg::TWO_ROUTING_OFS, 8'h01);
    wt(1);
    chk("duty off two", 8'h00, {6'h0, dfe1, dfe2});
    wr(10'h000, 8'hff);
    rd(10'h000);
    chk("unmapped", 8'h00, got);
    $display("duty test done");
    close_out();
  end
endmodule : tb_clock_channel_divider
